// file: rtl/mdcc_pkg.sv
package mdcc_pkg;

    // channel groups, as zero-based indices
    localparam int NCH    = 14;
    localparam int NFULL  = 3;
    localparam int NWRAP  = 10;
    localparam int NVFF   = 10;

    // global register byte offsets
    localparam logic [11:0] A_GSTA = 12'h000;
    localparam logic [11:0] A_GLIM = 12'h028;

    // per-channel offsets inside the channel page (channel n at n*0x100)
    localparam logic [7:0] O_SRC  = 8'h00;
    localparam logic [7:0] O_DST  = 8'h04;
    localparam logic [7:0] O_WPPT = 8'h08;
    localparam logic [7:0] O_WPTO = 8'h0C;
    localparam logic [7:0] O_CNT  = 8'h10;
    localparam logic [7:0] O_CON  = 8'h14;
    localparam logic [7:0] O_GO   = 8'h18;
    localparam logic [7:0] O_ISTA = 8'h1C;
    localparam logic [7:0] O_ACK  = 8'h20;
    localparam logic [7:0] O_RLCT = 8'h24;
    localparam logic [7:0] O_LIM  = 8'h28;
    localparam logic [7:0] O_PGM  = 8'h2C;

    // control word fields
    localparam int C_SOURCE_INCREMENT = 2;
    localparam int C_DESTINATION_INCREMENT = 3;
    localparam int C_DRQ  = 4;
    localparam int C_COMPLETION_IRQ_ENABLE = 15;
    localparam int C_WRAP_SIDE_SELECT = 16;
    localparam int C_WRAP_ENABLE = 17;
    localparam int C_DIR  = 18;
    localparam logic [31:0] CON_MASK = 32'h01F7_873F;
    localparam logic [1:0]  SZ_RSV   = 2'h3;

    // limiter encodings
    localparam logic [7:0] LIM_FREE  = 8'h00;
    localparam logic [7:0] LIM_BLOCK = 8'hFF;

    // fixed address of the peripheral side of half-size channels
    localparam logic [31:0] PERIPH_ADDR = 32'h0000_0000;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'h0,
        BUS_RESP = 2'h1
    } mdcc_bus_type;

    typedef struct packed {
        mdcc_bus_type          bus;
        logic [31:0]           rdata;
        logic [NCH-1:0]        go;
        logic [NCH-1:0]        run;
        logic [NCH-1:0]        irq;
        logic [NCH-1:0][31:0]  base_a;
        logic [NCH-1:0][31:0]  base_b;
        logic [NCH-1:0][31:0]  cur_a;
        logic [NCH-1:0][31:0]  cur_b;
        logic [NCH-1:0][15:0]  wppt;
        logic [NCH-1:0][31:0]  wpto;
        logic [NCH-1:0][15:0]  len;
        logic [NCH-1:0][15:0]  cnt;
        logic [NCH-1:0][31:0]  con;
        logic [NCH-1:0][7:0]   lim;
        logic [NCH-1:0][9:0]   limcnt;
        logic [NCH-1:0]        ack;
        logic                  xv;
        logic [3:0]            xch;
        logic [31:0]           xsrc;
        logic [31:0]           xdst;
        logic [1:0]            xsize;
    } mdcc_state_type;

endpackage : mdcc_pkg

// file: rtl/mdcc_top.sv
// Summary of operation
// - Global status shows per channel a run flag, 1 while transferring.
// - Global status shows per channel an interrupt-pending flag.
// - Writing the global limiter loads that limit into all 14 channels.
// - Channels 1-3: source write sets base, read returns current source.
// - Channels 1-3: destination write sets base, read returns current one.
// - Half-size channels: programmable address is destination if dir 1.
// - With wrapping, count equal to wrap point makes next address wrap-to.
// - Wrapping only on channels 1-10, enabled and sided by control bits.
// - Wrap-to register holds the jump address and reads back as written.
// - Channels 1-10 run length transfers, then interrupt if enabled.
// - Bytes moved equal length times the selected transfer size.
// - Virtual FIFO: length is threshold, compared by direction, if enabled.
// - Size field: 00 byte, 01 half-word, 10 word, 11 reserved.
// - Source increment adds 1, 2 or 4 per transfer, else fixed.
// - Destination increment adds 1, 2 or 4 per transfer, else fixed.
// - Hardware never clears the start bit; software writes 0.
// - Limiter 0 free, 255 blocked, n grants once every 4n clocks.
// - Acknowledge write 1 clears pending interrupt; reads return 0.
// - Channels 4-14: dir 1 moves master data to the programmable address.
`timescale 1ns/1ps
`default_nettype none

module mdcc_top
    import mdcc_pkg::*;
(
    // clock and reset
    input  wire logic                clk_sys_i,
    input  wire logic                nrst_i,
    // avalon-mm slave
    input  wire logic [11:0]         avs_address_i,
    input  wire logic                avs_read_i,
    input  wire logic                avs_write_i,
    input  wire logic [31:0]         avs_writedata_i,
    input  wire logic [3:0]          avs_byteenable_i,
    output logic      [31:0]         avs_readdata_o,
    output logic                     avs_waitrequest_o,
    // peripheral handshake
    input  wire logic [NCH-1:0]      req_i,
    output logic      [NCH-1:0]      ack_o,
    input  wire logic [3:0][15:0]    vff_cnt_i,
    // transfer issue
    output logic                     xfer_valid_o,
    output logic      [3:0]          xfer_ch_o,
    output logic      [31:0]         xfer_src_o,
    output logic      [31:0]         xfer_dst_o,
    output logic      [1:0]          xfer_size_o
);

    mdcc_state_type q;
    mdcc_state_type d;

    logic [27:0] sta;
    logic [31:0] rv;
    logic [31:0] bm;
    logic [31:0] wv;
    logic [3:0]  cn;
    logic [3:0]  ci;
    logic [7:0]  off;
    logic        chv;
    logic        found;
    logic [1:0]  sz;
    logic [31:0] step;
    logic        half;
    logic        a_dst;
    logic        wrap;
    logic        hit;
    logic        more;
    logic        vff;
    logic        lim_ok;
    logic [15:0] fc;

    assign cn  = avs_address_i[11:8];
    assign ci  = cn - 4'h1;
    assign off = avs_address_i[7:0];
    assign chv = (cn != 4'h0) && (cn <= 4'(NCH));

    always_comb begin
        d = q;
        d.ack = '0;
        d.xv = 1'b0;
        found = 1'b0;
        sz = 2'h0;
        step = 32'h0;
        half = 1'b0;
        a_dst = 1'b0;
        wrap = 1'b0;
        hit = 1'b0;
        more = 1'b0;
        vff = 1'b0;
        lim_ok = 1'b0;
        fc = 16'h0;
        rv = 32'h0;
        bm = 32'h0;

        for (int i = 0; i < NCH; i++) begin
            sta[2*i]   = q.run[i];
            sta[2*i+1] = q.irq[i];
        end

        // read view of the addressed register; write merges into it
        if (avs_address_i == A_GSTA) begin
            rv = {4'h0, sta};
        end else if (chv) begin
            case (off)
                O_SRC:  if (ci < NFULL) rv = q.cur_a[ci];
                O_DST:  if (ci < NFULL) rv = q.cur_b[ci];
                O_WPPT: if (ci < NWRAP) rv = {16'h0, q.wppt[ci]};
                O_WPTO: if (ci < NWRAP) rv = q.wpto[ci];
                O_CNT:  rv = {16'h0, q.len[ci]};
                O_CON:  rv = q.con[ci];
                O_GO:   rv = {31'h0, q.go[ci]};
                O_ISTA: rv = {31'h0, q.irq[ci]};
                O_RLCT: if (ci < NWRAP) rv = {16'h0, q.len[ci] - q.cnt[ci]};
                O_LIM:  rv = {24'h0, q.lim[ci]};
                O_PGM:  if (ci >= NFULL) rv = q.cur_a[ci];
                default: rv = 32'h0;
            endcase
        end
        for (int b = 0; b < 4; b++) begin
            bm[8*b +: 8] = {8{avs_byteenable_i[b]}};
        end
        wv = (rv & ~bm) | (avs_writedata_i & bm);

        case (q.bus)
            BUS_IDLE: begin
                if (avs_read_i || avs_write_i) begin
                    d.bus = BUS_RESP;
                    d.rdata = avs_read_i ? rv : 32'h0;
                end
            end
            BUS_RESP: begin
                d.bus = BUS_IDLE;
                if (avs_write_i && avs_address_i == A_GLIM) begin
                    for (int i = 0; i < NCH; i++) begin
                        d.lim[i] = wv[7:0];
                    end
                end else if (avs_write_i && chv) begin
                    case (off)
                        O_SRC: if (ci < NFULL) begin
                            d.base_a[ci] = wv;
                            d.cur_a[ci] = wv;
                        end
                        O_DST: if (ci < NFULL) begin
                            d.base_b[ci] = wv;
                            d.cur_b[ci] = wv;
                        end
                        O_PGM: if (ci >= NFULL) begin
                            d.base_a[ci] = wv;
                            d.cur_a[ci] = wv;
                        end
                        O_WPPT: if (ci < NWRAP) d.wppt[ci] = wv[15:0];
                        O_WPTO: if (ci < NWRAP) d.wpto[ci] = wv;
                        O_CNT:  d.len[ci] = wv[15:0];
                        O_CON:  d.con[ci] = wv & CON_MASK;
                        O_LIM:  d.lim[ci] = wv[7:0];
                        O_ACK:  if (wv[0]) d.irq[ci] = 1'b0;
                        O_GO: begin
                            d.go[ci] = wv[0];
                            if (wv[0] && !q.go[ci]) begin
                                // a fresh start reloads the working addresses
                                d.run[ci] = 1'b1;
                                d.cnt[ci] = 16'h0;
                                d.cur_a[ci] = q.base_a[ci];
                                d.cur_b[ci] = q.base_b[ci];
                                d.limcnt[ci] = 10'h0;
                            end else if (!wv[0]) begin
                                d.run[ci] = 1'b0;
                            end
                        end
                        default: ;
                    endcase
                end
            end
            default: d.bus = BUS_IDLE;
        endcase

        // engine runs after the bus so that a set beats a clear
        for (int i = 0; i < NCH; i++) begin
            sz = q.con[i][1:0];
            step = (sz == SZ_RSV) ? 32'h0 : (32'h1 << sz);
            half = (i >= NFULL);
            vff = (i >= NVFF);
            a_dst = half && q.con[i][C_DIR];
            wrap = (i < NWRAP) && q.con[i][C_WRAP_ENABLE];
            hit = wrap && (q.cnt[i] + 16'h1 == q.wppt[i]);
            more = vff || (q.cnt[i] < q.len[i]);
            lim_ok = (q.lim[i] == LIM_FREE) ||
                     (q.lim[i] != LIM_BLOCK && q.limcnt[i] == 10'h0);
            fc = vff_cnt_i[2'(i - NVFF)];

            if (q.limcnt[i] != 10'h0) begin
                d.limcnt[i] = q.limcnt[i] - 10'h1;
            end
            if (q.run[i] && !more) begin
                d.run[i] = 1'b0;
                if (q.con[i][C_COMPLETION_IRQ_ENABLE]) d.irq[i] = 1'b1;
            end
            if (vff && q.go[i] && q.con[i][C_COMPLETION_IRQ_ENABLE] &&
                (q.con[i][C_DIR] ? fc >= q.len[i] : fc <= q.len[i])) begin
                d.irq[i] = 1'b1;
            end

            if (!found && q.run[i] && more && lim_ok &&
                (req_i[i] || !q.con[i][C_DRQ])) begin
                found = 1'b1;
                if (!vff) d.cnt[i] = q.cnt[i] + 16'h1;
                if (q.lim[i] != LIM_FREE) begin
                    d.limcnt[i] = {q.lim[i], 2'b00} - 10'h1;
                end
                d.ack[i] = 1'b1;
                d.xv = 1'b1;
                d.xch = 4'(i + 1);
                d.xsize = sz;
                d.xsrc = (half && a_dst) ? PERIPH_ADDR : q.cur_a[i];
                d.xdst = half ? (a_dst ? q.cur_a[i] : PERIPH_ADDR) : q.cur_b[i];

                if (hit && (q.con[i][C_WRAP_SIDE_SELECT] == a_dst)) begin
                    d.cur_a[i] = q.wpto[i];
                end else if (a_dst ? q.con[i][C_DESTINATION_INCREMENT] : q.con[i][C_SOURCE_INCREMENT]) begin
                    d.cur_a[i] = q.cur_a[i] + step;
                end
                if (hit && !half && q.con[i][C_WRAP_SIDE_SELECT]) begin
                    d.cur_b[i] = q.wpto[i];
                end else if (!half && q.con[i][C_DESTINATION_INCREMENT]) begin
                    d.cur_b[i] = q.cur_b[i] + step;
                end
            end
        end
    end

    // the start bit only changes on a bus write
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign avs_waitrequest_o = (q.bus == BUS_IDLE) && (avs_read_i || avs_write_i);
    assign avs_readdata_o    = q.rdata;
    assign ack_o             = q.ack;
    assign xfer_valid_o      = q.xv;
    assign xfer_ch_o         = q.xch;
    assign xfer_src_o        = q.xsrc;
    assign xfer_dst_o        = q.xdst;
    assign xfer_size_o       = q.xsize;

    logic wr_acc;
    assign wr_acc = (q.bus == BUS_RESP) && avs_write_i;

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);

    property p_start_run;
        wr_acc && avs_address_i == 12'h118 && avs_byteenable_i[0] &&
        avs_writedata_i[0] && !q.go[0] |=> q.run[0] && sta[0];
    endproperty
    a_start_run: assert property (p_start_run) else $error("start did not run");

    property p_go_sticky;
        $fell(q.go[1]) |-> $past(wr_acc && avs_address_i == 12'h218);
    endproperty
    a_go_sticky: assert property (p_go_sticky) else $error("start bit cleared by hw");

    property p_glb_lim;
        wr_acc && avs_address_i == A_GLIM && avs_byteenable_i == 4'hF
        |=> q.lim[0] == $past(avs_writedata_i[7:0]) && q.lim[13] == q.lim[0];
    endproperty
    a_glb_lim: assert property (p_glb_lim) else $error("global limit not loaded");

    property p_irq_completion_irq_enable;
        $rose(q.irq[0]) |-> $past(q.con[0][C_COMPLETION_IRQ_ENABLE]);
    endproperty
    a_irq_completion_irq_enable: assert property (p_irq_completion_irq_enable) else $error("irq without enable");

    property p_src_step;
        q.ack[0] && $past(q.con[0][C_SOURCE_INCREMENT]) && !$past(q.con[0][C_WRAP_ENABLE]) &&
        $past(q.con[0][1:0]) == 2'h2 |-> q.cur_a[0] == $past(q.cur_a[0]) + 32'h4;
    endproperty
    a_src_step: assert property (p_src_step) else $error("word step wrong");

    // destination-side wrap on a full-size channel lands on the wrap-to address
    property p_wrap;
        q.ack[1] && $past(q.con[1][C_WRAP_ENABLE]) && $past(q.con[1][C_WRAP_SIDE_SELECT]) &&
        $past(q.cnt[1]) + 16'h1 == $past(q.wppt[1]) |-> q.cur_b[1] == $past(q.wpto[1]);
    endproperty
    a_wrap: assert property (p_wrap) else $error("wrap not taken");

    property p_blocked;
        q.lim[4] == LIM_BLOCK && $past(q.lim[4]) == LIM_BLOCK |-> !q.ack[4];
    endproperty
    a_blocked: assert property (p_blocked) else $error("blocked channel granted");

    property p_spacing;
        q.ack[4] && q.lim[4] == 8'h02 |=> !q.ack[4] [*7];
    endproperty
    a_spacing: assert property (p_spacing) else $error("limiter spacing short");

    property p_ack_read;
        q.bus == BUS_RESP && avs_read_i && chv && off == O_ACK |-> avs_readdata_o == 32'h0;
    endproperty
    a_ack_read: assert property (p_ack_read) else $error("ack reads nonzero");

    property p_bus_answer;
        avs_read_i || avs_write_i |-> ##[0:1] !avs_waitrequest_o;
    endproperty
    a_bus_answer: assert property (p_bus_answer) else $error("bus answer late");

    c_done_irq: cover property ($rose(q.irq[0]) && !q.run[0]);
    c_vff_irq:  cover property ($rose(q.irq[10]));
    c_wrap:     cover property (q.ack[1] && q.con[1][C_WRAP_ENABLE]);

endmodule : mdcc_top

`default_nettype wire

// file: verification/mdcc_periph_model.sv
`timescale 1ns/1ps
`default_nettype none

module mdcc_periph_model
    import mdcc_pkg::*;
(
    // clock and reset
    input  wire logic           clk_sys_i,
    input  wire logic           nrst_i,
    // traffic control from the bench
    input  wire logic [NCH-1:0] en_i,
    input  wire logic [NCH-1:0] stall_i,
    // handshake
    output logic      [NCH-1:0] req_o
);
    // a master holds its request level while it has data, and may pause between units
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            req_o <= '0;
        end else begin
            req_o <= en_i & ~stall_i;
        end
    end
endmodule : mdcc_periph_model

`default_nettype wire

// file: verification/mdcc_top_tb.sv
`timescale 1ns/1ps
`default_nettype none

module mdcc_top_tb;
    import mdcc_pkg::*;

    logic             clk_sys_i = 1'b0;
    logic             nrst_i = 1'b0;
    logic [11:0]      avs_address_i = '0;
    logic             avs_read_i = 1'b0;
    logic             avs_write_i = 1'b0;
    logic [31:0]      avs_writedata_i = '0;
    logic [31:0]      avs_readdata_o;
    logic             avs_waitrequest_o;
    logic [NCH-1:0]   req_i;
    logic [NCH-1:0]   ack_o;
    logic [NCH-1:0]   req_en = '0;
    logic [NCH-1:0]   stall = '0;
    logic             slow = 1'b0;
    logic [3:0][15:0] vff_cnt_i = '0;
    logic             xfer_valid_o;
    logic [3:0]       xfer_ch_o;
    logic [31:0]      xfer_src_o;
    logic [31:0]      xfer_dst_o;
    logic [1:0]       xfer_size_o;
    logic [3:0]       exp_ch = '0;
    logic [1:0]       exp_sz = '0;
    int               miscompares = 0;
    int               n_tests = 0;
    int               cyc = 0;
    int               seed = 32'hD368EF40;
    logic [31:0]      q_s[$];
    logic [31:0]      q_d[$];
    int               q_t[$];

    mdcc_top uut (
        .clk_sys_i, .nrst_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
        .avs_byteenable_i(4'hF), .avs_readdata_o, .avs_waitrequest_o, .req_i, .ack_o,
        .vff_cnt_i, .xfer_valid_o, .xfer_ch_o, .xfer_src_o, .xfer_dst_o, .xfer_size_o
    );

    mdcc_periph_model periph (
        .clk_sys_i, .nrst_i, .en_i(req_en), .stall_i(stall), .req_o(req_i)
    );

    initial begin
        forever #5 clk_sys_i = ~clk_sys_i;
    end

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic stop_test;
        $display("comparisons %0d miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : stop_test

    // outputs are logged as they stood in the cycle that ends at this edge
    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        stall <= slow ? NCH'($random(seed)) : '0;
        if (xfer_valid_o === 1'b1) begin
            q_s.push_back(xfer_src_o);
            q_d.push_back(xfer_dst_o);
            q_t.push_back(cyc);
            chk("xch", 32'(xfer_ch_o), 32'(exp_ch));
            chk("xsize", 32'(xfer_size_o), 32'(exp_sz));
            chk("ack", 32'(ack_o), 32'h1 << (exp_ch - 4'h1));
        end
    end

    function automatic logic [11:0] ra(input int ch, input logic [7:0] o);
        return {4'(ch), o};
    endfunction : ra

    function automatic logic [31:0] stp(input logic [1:0] z);
        return (z == SZ_RSV) ? 32'h0 : 32'h1 << z;
    endfunction : stp

    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_write_i <= w;
        avs_read_i <= !w;
        // the answer is taken at the very edge that sees waitrequest low; the watchdog ends a hang
        do begin
            @(posedge clk_sys_i);
        end while (avs_waitrequest_o !== 1'b0);
        q = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
        @(posedge clk_sys_i);
    endtask : bus

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr

    task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(nm, q, e);
    endtask : rdc

    task automatic go(input int ch, input int n, input logic completion_irq_enable);
        q_s.delete();
        q_d.delete();
        q_t.delete();
        exp_ch = 4'(ch);
        wr(ra(ch, O_GO), 32'h1);
        rdc("run", A_GSTA, 32'h1 << (2 * ch - 2));
        req_en[ch-1] <= 1'b1;
        for (int k = 0; k < 400 && q_s.size() < n; k++) @(posedge clk_sys_i);
        repeat (3) @(posedge clk_sys_i);
        req_en[ch-1] <= 1'b0;
        chk("count", q_s.size(), n);
        rdc("done", A_GSTA, 32'(completion_irq_enable) << (2 * ch - 1));
        rdc("ista", ra(ch, O_ISTA), 32'(completion_irq_enable));
        rdc("start", ra(ch, O_GO), 32'h1);
        wr(ra(ch, O_ACK), 32'h1);
        rdc("ackrd", ra(ch, O_ACK), 32'h0);
        rdc("acked", A_GSTA, 32'h0);
        wr(ra(ch, O_GO), 32'h0);
    endtask : go

    initial begin
        logic [31:0] s;
        logic [31:0] d;
        logic [31:0] w;
        logic [1:0]  inc;
        repeat (8) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        @(posedge clk_sys_i);
        rdc("gsta", A_GSTA, 32'h0);
        rdc("con", ra(1, O_CON), 32'h0);
        rdc("glim", A_GLIM, 32'h0);
        rdc("unmapped", 12'hFFC, 32'h0);
        for (int i = 0; i < 3; i++) begin
            s = $random(seed);
            d = $random(seed);
            // the word pass always steps the source so the word-step property is exercised
            inc = 2'($random(seed)) | 2'(i == 2);
            exp_sz = 2'(i);
            slow = (i == 2);
            wr(ra(1, O_SRC), s);
            wr(ra(1, O_DST), d);
            rdc("src", ra(1, O_SRC), s);
            rdc("dst", ra(1, O_DST), d);
            wr(ra(1, O_CNT), 32'h5);
            wr(ra(1, O_CON), 32'(i) | 32'(inc) << C_SOURCE_INCREMENT | 32'h1 << C_DRQ | 32'(i != 1) << C_COMPLETION_IRQ_ENABLE);
            go(1, 5, i != 1);
            for (int k = 0; k < q_s.size(); k++) begin
                chk("xsrc", q_s[k], s + k * stp(exp_sz) * inc[0]);
                chk("xdst", q_d[k], d + k * stp(exp_sz) * inc[1]);
            end
            rdc("cursrc", ra(1, O_SRC), s + 5 * stp(exp_sz) * inc[0]);
        end
        slow = 1'b0;
        s = $random(seed) & 32'hFFFF_FFFC;
        d = $random(seed) & 32'hFFFF_FFFC;
        w = $random(seed) & 32'hFFFF_FFFC;
        exp_sz = 2'h2;
        wr(ra(2, O_SRC), s);
        wr(ra(2, O_DST), d);
        wr(ra(2, O_WPTO), w);
        wr(ra(2, O_WPPT), 32'h2);
        rdc("wpto", ra(2, O_WPTO), w);
        wr(ra(2, O_CNT), 32'h4);
        wr(ra(2, O_CON), 32'h2 | 32'hC | 32'h1 << C_DRQ | 32'h1 << C_WRAP_SIDE_SELECT | 32'h1 << C_WRAP_ENABLE);
        go(2, 4, 1'b0);
        for (int k = 0; k < q_s.size(); k++) begin
            chk("wsrc", q_s[k], s + 4 * k);
            chk("wdst", q_d[k], (k < 2) ? d + 4 * k : w + 4 * (k - 2));
        end
        exp_sz = 2'h0;
        for (int dir = 0; dir < 2; dir++) begin
            w = $random(seed);
            wr(ra(4, O_PGM), w);
            wr(ra(4, O_CNT), 32'h3);
            wr(ra(4, O_CON), 32'h1 << (dir ? C_DESTINATION_INCREMENT : C_SOURCE_INCREMENT) | 32'h1 << C_DRQ |
                             32'(dir) << C_DIR | 32'h1 << C_COMPLETION_IRQ_ENABLE);
            go(4, 3, 1'b1);
            for (int k = 0; k < q_s.size(); k++) begin
                chk("hsrc", q_s[k], dir ? PERIPH_ADDR : w + k);
                chk("hdst", q_d[k], dir ? w + k : PERIPH_ADDR);
            end
        end
        wr(A_GLIM, 32'h2);
        rdc("lim5", ra(5, O_LIM), 32'h2);
        rdc("lim14", ra(14, O_LIM), 32'h2);
        exp_sz = 2'h1;
        wr(ra(5, O_CNT), 32'h3);
        wr(ra(5, O_CON), 32'h1 | 32'h1 << C_DRQ);
        go(5, 3, 1'b0);
        for (int k = 1; k < q_t.size(); k++) chk("gap", q_t[k] - q_t[k-1], 32'h8);
        wr(ra(5, O_LIM), 32'(LIM_BLOCK));
        q_s.delete();
        wr(ra(5, O_GO), 32'h1);
        req_en[4] <= 1'b1;
        repeat (60) @(posedge clk_sys_i);
        chk("blocked", q_s.size(), 0);
        req_en[4] <= 1'b0;
        wr(ra(5, O_GO), 32'h0);
        wr(A_GLIM, 32'h0);
        // receive compares at or above, transmit at or below the threshold
        wr(ra(11, O_CNT), 32'h5);
        for (int i = 0; i < 4; i++) begin
            wr(ra(11, O_GO), 32'h0);
            wr(ra(11, O_CON), 32'h1 << C_COMPLETION_IRQ_ENABLE | 32'h1 << C_DRQ | 32'(i < 2) << C_DIR);
            wr(ra(11, O_GO), 32'h1);
            vff_cnt_i[0] <= 16'(i == 0 ? 4 : i == 2 ? 6 : 5);
            wr(ra(11, O_ACK), 32'h1);
            rdc("vff", ra(11, O_ISTA), 32'(i % 2));
        end
        wr(ra(11, O_GO), 32'h0);
        stop_test();
    end

    initial begin
        repeat (20000) @(posedge clk_sys_i);
        miscompares++;
        stop_test();
    end
endmodule : mdcc_top_tb

`default_nettype wire
